// *** verilog/msc_consts.svh ***
// constants for the multi-module synchronisation control block
// assumes inclusion by the package and the design modules only
// How it works
// - software picks one of three sync settings: master, slave or none
// - after reset the setting is none; internal clock paces sampling, link ignored
// - in none mode one internal clock paces both input and output sampling
// - master drives its start trigger and sample clock onto the link
// - slave takes trigger and clock from link; local trigger sources disabled
// - setting holds until software writes anew or the session ends
// - master and slaves do not start in the same cycle; a slave can lag the master by up to two sample periods plus three REF_CLK cycles
// - each module sets its own sample rate divider; a slave ignores it and paces from the link clock
// - master stop does not stop slaves; each slave stops on its own stop
// - without link, shared external trigger starts each module unaligned
// - local external trigger fires on rising edge, only when not slave
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
`define MSC_DIV_W 16
`define MSC_DIV_ONE 16'h0001
`define MSC_DIV_ZERO 16'h0000
`define MSC_MODE_RSVD 2'h3
`endif

// *** verilog/msc_pkg.sv ***
// types shared by the synchronisation control modules
// assumes msc_consts.svh is on the include path
package msc_pkg;
  `include "msc_consts.svh"
  typedef enum logic [1:0] {
    MSC_NONE,
    MSC_MASTER,
    MSC_SLAVE
  } msc_mode_e;
  typedef enum logic [1:0] {
    MSC_IDLE,
    MSC_ARMED,
    MSC_RUN
  } msc_acq_e;
endpackage

// *** verilog/msc_sync2.sv ***
// two-flop level synchroniser
// assumes an asynchronous input and one destination clock
module msc_sync2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta;
  logic next_meta;
  logic next_dout;
  always_comb begin
    next_meta = din;
    next_dout = meta;
    if (rst) begin
      next_meta = 1'b0;
      next_dout = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    meta <= next_meta;
    dout <= next_dout;
  end
endmodule

// *** verilog/msc_top.sv ***
// sync control: chooses the sample clock and start trigger source
// assumes control inputs on REF_CLK, LINK_CLK from the master over the link
`include "msc_consts.svh"
module msc_top
  import msc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire logic [1:0] MODE_SET,
  input wire logic MODE_WR,
  input wire logic SESSION_END,
  input wire logic [`MSC_DIV_W-1:0] RATE_DIV,
  input wire logic ARM,
  input wire logic SW_TRIG,
  input wire logic STOP,
  input wire logic EXT_TRIG,
  input wire logic THRESH_TRIG,
  input wire logic LINK_TRIG_IN,
  output logic LINK_TRIG_OUT,
  output logic LINK_TRIG_OE,
  output logic LINK_CLK_OUT,
  output logic LINK_CLK_OE,
  output logic [1:0] MODE,
  output logic ACQ_RUN,
  output logic SAMPLE_TICK,
  output logic AO_TICK
);
  ////////////////////////////////////////////////////////////
  // mode decode, shared by source selection and link drivers
  function automatic logic is_master(input msc_mode_e m);
    return m == MSC_MASTER;
  endfunction
  function automatic logic is_slave(input msc_mode_e m);
    return m == MSC_SLAVE;
  endfunction
  ////////////////////////////////////////////////////////////
  // mode register
  // reserved code is dropped so a bad write cannot leave an illegal state
  msc_mode_e mode;
  msc_mode_e next_mode;
  always_comb begin
    next_mode = mode;
    if (MODE_WR && MODE_SET != `MSC_MODE_RSVD) begin
      next_mode = msc_mode_e'(MODE_SET);
    end
    if (SESSION_END || RST) begin
      next_mode = MSC_NONE;
    end
  end
  always_ff @(posedge REF_CLK) begin
    mode <= next_mode;
  end
  assign MODE = mode;
  ////////////////////////////////////////////////////////////
  // link clock seen in REF_CLK domain as a level, edge gives the tick
  logic link_clk_s;
  logic link_clk_d;
  logic link_trig_s;
  msc_sync2 u_clk_sync (
    .clk(REF_CLK),
    .rst(RST),
    .din(LINK_CLK),
    .dout(link_clk_s)
  );
  // trigger is caught on the link clock, then brought across
  // single bit level, so two flops are enough for the crossing
  logic link_trig_lc;
  always_ff @(posedge LINK_CLK) begin
    link_trig_lc <= LINK_TRIG_IN;
  end
  msc_sync2 u_trig_sync (
    .clk(REF_CLK),
    .rst(RST),
    .din(link_trig_lc),
    .dout(link_trig_s)
  );
  logic ext_s;
  logic ext_d;
  logic thr_s;
  msc_sync2 u_ext_sync (
    .clk(REF_CLK),
    .rst(RST),
    .din(EXT_TRIG),
    .dout(ext_s)
  );
  msc_sync2 u_thr_sync (
    .clk(REF_CLK),
    .rst(RST),
    .din(THRESH_TRIG),
    .dout(thr_s)
  );
  ////////////////////////////////////////////////////////////
  // internal timebase: one divider paces input and output alike
  logic [`MSC_DIV_W-1:0] div_cnt;
  logic [`MSC_DIV_W-1:0] next_div_cnt;
  logic int_tick;
  logic link_tick;
  logic link_trig_d;
  logic next_link_clk_d;
  logic next_ext_d;
  logic next_link_trig_d;
  // a divider of zero ticks on every cycle
  assign int_tick = (div_cnt == `MSC_DIV_ZERO);
  // edge registers clear to the idle low level, so no false edge after reset
  assign link_tick = link_clk_s && !link_clk_d;
  always_comb begin
    next_div_cnt = int_tick ? RATE_DIV : div_cnt - `MSC_DIV_ONE;
    next_link_clk_d = link_clk_s;
    next_ext_d = ext_s;
    next_link_trig_d = link_trig_s;
    if (RST) begin
      next_div_cnt = `MSC_DIV_ZERO;
      next_link_clk_d = 1'b0;
      next_ext_d = 1'b0;
      next_link_trig_d = 1'b0;
    end
  end
  always_ff @(posedge REF_CLK) begin
    div_cnt <= next_div_cnt;
    link_clk_d <= next_link_clk_d;
    ext_d <= next_ext_d;
    link_trig_d <= next_link_trig_d;
  end
  ////////////////////////////////////////////////////////////
  // start source selection
  logic local_start;
  logic link_start;
  logic start_ev;
  logic pace;
  always_comb begin
    local_start = SW_TRIG || (ext_s && !ext_d) || thr_s;
    link_start = link_trig_s && !link_trig_d;
    start_ev = is_slave(mode) ? link_start : local_start;
    pace = is_slave(mode) ? link_tick : int_tick;
  end
  ////////////////////////////////////////////////////////////
  // acquisition state; stop is local only
  msc_acq_e acq;
  msc_acq_e next_acq;
  logic trig_out;
  logic next_trig_out;
  logic clk_out;
  logic next_clk_out;
  logic sample_tick;
  logic next_sample_tick;
  logic ao_tick;
  logic next_ao_tick;
  always_comb begin
    next_acq = acq;
    case (acq)
      MSC_IDLE: begin
        if (ARM) begin
          next_acq = MSC_ARMED;
        end
      end
      MSC_ARMED: begin
        if (STOP) begin
          next_acq = MSC_IDLE;
        end else if (start_ev) begin
          next_acq = MSC_RUN;
        end
      end
      MSC_RUN: begin
        if (STOP) begin
          next_acq = MSC_IDLE;
        end
      end
      default: next_acq = MSC_IDLE;
    endcase
    // master repeats its start onto link; slaves see it three flops later, the first on LINK_CLK, up to two sample periods plus two REF_CLK cycles
    next_trig_out = is_master(mode) && (acq == MSC_ARMED) && start_ev;
    if (is_master(mode) && trig_out) begin
      next_trig_out = 1'b1;
    end
    if (acq == MSC_IDLE) begin
      next_trig_out = 1'b0;
    end
    next_clk_out = clk_out;
    if (int_tick) begin
      next_clk_out = !clk_out;
    end
    next_sample_tick = pace && (acq == MSC_RUN);
    next_ao_tick = pace;
    if (RST) begin
      next_acq = MSC_IDLE;
      next_trig_out = 1'b0;
      next_clk_out = 1'b0;
      next_sample_tick = 1'b0;
      next_ao_tick = 1'b0;
    end
  end
  always_ff @(posedge REF_CLK) begin
    acq <= next_acq;
    trig_out <= next_trig_out;
    clk_out <= next_clk_out;
    sample_tick <= next_sample_tick;
    ao_tick <= next_ao_tick;
  end
  assign LINK_TRIG_OUT = trig_out;
  assign LINK_CLK_OUT = clk_out;
  // link pins are driven only by the master, so peers never fight
  assign LINK_TRIG_OE = is_master(mode);
  assign LINK_CLK_OE = is_master(mode);
  assign ACQ_RUN = (acq == MSC_RUN);
  assign SAMPLE_TICK = sample_tick;
  assign AO_TICK = ao_tick;
endmodule

// *** dv/msc_top_properties.sv ***
// port assertions for msc_top
// assumes a bind to msc_top, one domain on REF_CLK
module msc_top_properties (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [1:0] MODE_SET,
  input wire logic MODE_WR,
  input wire logic SESSION_END,
  input wire logic ARM,
  input wire logic SW_TRIG,
  input wire logic STOP,
  input wire logic [1:0] MODE,
  input wire logic ACQ_RUN,
  input wire logic LINK_TRIG_OUT,
  input wire logic LINK_TRIG_OE
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // code 3 is refused, so it counts as no write
  wire wr = MODE_WR && MODE_SET != 2'h3;
  sequence s_go;
    ARM && !STOP && !ACQ_RUN ##1 SW_TRIG && !STOP && MODE != 2'h2;
  endsequence
  chk_mode_load: assert property (wr && !SESSION_END |=> MODE == $past(MODE_SET)) else $error("load");
  chk_mode_keep: assert property (!wr && !SESSION_END |=> $stable(MODE)) else $error("keep");
  chk_session_clr: assert property (SESSION_END && !MODE_WR |=> MODE == 2'h0) else $error("end");
  chk_master_oe: assert property (LINK_TRIG_OE == (MODE == 2'h1)) else $error("oe");
  chk_soft_start: assert property (s_go |=> ACQ_RUN) else $error("start");
  chk_local_stop: assert property (STOP |=> !ACQ_RUN) else $error("stop");
  chk_trig_drive: assert property ($rose(ACQ_RUN) && MODE == 2'h1 |-> LINK_TRIG_OUT) else $error("trig");
  chk_trig_free: assert property ($fell(ACQ_RUN) |=> !LINK_TRIG_OUT) else $error("free");
endmodule
bind msc_top msc_top_properties msc_top_properties_i (.*);

// *** dv/msc_peer.sv ***
// link peer acting as master: sample clock and start level
// assumes run rises only once every slave is armed
module msc_peer (
  input wire logic run,
  output logic link_clk,
  output logic link_trig
);
  timeunit 1ns;
  timeprecision 100ps;
  initial link_clk = 0;
  initial link_trig = 0;
  always #24 link_clk = ~link_clk;
  // one peer only, holds start high while running
  always @(posedge link_clk) link_trig <= run;
endmodule

// *** dv/msc_top_bench.sv ***
// self-checking bench for msc_top with a link peer
// assumes msc_pkg, msc_top and the checker are compiled first
module msc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // names follow the ports so the instance connects by name
  logic REF_CLK = 0, RST = 1, MODE_WR = 0, SESSION_END = 0, ARM = 0, SW_TRIG = 0, STOP = 0;
  logic EXT_TRIG = 0, THRESH_TRIG = 0, run = 0, LINK_CLK, LINK_TRIG_IN, LINK_CLK_OUT, LINK_CLK_OE;
  logic LINK_TRIG_OUT, LINK_TRIG_OE, ACQ_RUN, SAMPLE_TICK, AO_TICK;
  logic [1:0] MODE_SET = 0, MODE;
  logic [15:0] RATE_DIV = 0;
  int n_mismatch = 0, checks_done = 0, n, ns, nt;
  msc_top msc_top_i (.*);
  msc_peer msc_peer_i (.run(run), .link_clk(LINK_CLK), .link_trig(LINK_TRIG_IN));
  always #2 REF_CLK = ~REF_CLK;
  function automatic int gap(input logic [15:0] d);
    return d + 1;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge REF_CLK);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    n_mismatch += int'(ok !== 1'b1);
    if (ok !== 1'b1) $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  task automatic await(input logic e, input int lim);
    repeat (lim) if (ACQ_RUN !== e) tick(1);
    chk(ACQ_RUN === e, "run");
  endtask
  // one internal period: counts sample ticks and link clock toggles
  task automatic span(output int s, output int t);
    logic c;
    s = 0;
    t = 0;
    c = LINK_CLK_OUT;
    repeat (gap(RATE_DIV)) begin
      tick(1);
      s += int'(SAMPLE_TICK === 1'b1);
      t += int'(LINK_CLK_OUT !== c);
      c = LINK_CLK_OUT;
    end
  endtask
  task automatic wmode(input logic [1:0] m);
    MODE_SET = m;
    pulse(MODE_WR);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h01DF));
    RATE_DIV = 16'($urandom % 4);
    tick(4);
    RST = 0;
    chk(MODE === 2'h0 && LINK_TRIG_OE === 1'b0, "reset");
    repeat (9) if (AO_TICK !== 1'b1) tick(1);
    tick(1);
    for (n = 1; AO_TICK !== 1'b1 && n < 9; n++) tick(1);
    chk(n == gap(RATE_DIV), "pace");
    // code 3 first, while the mode is still none
    for (int m = 3; m >= 0; m--) begin
      wmode(2'(m));
      chk(MODE === 2'(m % 3) && LINK_TRIG_OE === (m == 1), "mode");
      tick(1);
    end
    wmode(2'h1);
    pulse(ARM);
    pulse(SW_TRIG);
    await(1, 3);
    chk(LINK_TRIG_OUT === 1'b1, "trig");
    chk(LINK_CLK_OE === 1'b1, "clk oe");
    span(ns, nt);
    chk(ns == 1 && nt == 1, "ticks");
    pulse(STOP);
    await(0, 2);
    wmode(2'h0);
    pulse(ARM);
    EXT_TRIG = 1;
    await(1, 8);
    EXT_TRIG = 0;
    pulse(STOP);
    wmode(2'h2);
    pulse(ARM);
    EXT_TRIG = 1;
    THRESH_TRIG = 1;
    pulse(SW_TRIG);
    tick(20);
    chk(ACQ_RUN === 1'b0, "local");
    EXT_TRIG = 0;
    THRESH_TRIG = 0;
    run = 1;
    await(1, 40);
    run = 0;
    tick(40);
    chk(ACQ_RUN === 1'b1, "kept");
    pulse(STOP);
    await(0, 2);
    pulse(SESSION_END);
    chk(MODE === 2'h0, "end");
    complete_run();
  end
endmodule
